// ### common/pwr_state_pkg.sv
// Purpose: Shared constants and types for the power state controller
// Assumes: 32-bit Avalon-MM register bus, word-aligned byte addresses
// Notes: Register offsets and gpio_cfg / pull_ctrl reset values live here
package pwr_state_pkg;

    // ========================================
    // Register map (byte addresses)
    localparam logic [3:0] power_ctrl_addr = 4'h0;
    localparam logic [3:0] power_stat_addr = 4'h4;
    localparam logic [3:0] gpio_cfg_addr = 4'h8;
    localparam logic [3:0] pull_ctrl_addr = 4'hc;

    // ========================================
    // Field positions
    localparam int idle_request_bit_pos = 0;
    localparam int gpio_count = 8;
    localparam int wake_en_lsb = 8;
    localparam int irq_en_lsb = 0;

    // ========================================
    // Reset values and answers
    localparam logic [31:0] gpio_cfg_reset = 32'h0000_0000;
    localparam logic [15:0] pull_ctrl_reset = 16'h0000;
    localparam logic [31:0] unmapped_read = 32'h0000_0000;

    // ========================================
    // Timing: clock restart settle time after wake-up
    localparam int clk_freq_mhz = 25;
    localparam int clk_settle_ns = 1000;
    localparam int clk_settle_cycles = (clk_settle_ns * clk_freq_mhz + 999) / 1000;
    localparam logic [7:0] settle_count = 8'(clk_settle_cycles);

    typedef enum logic [1:0] {st_reset, st_normal, st_idle, st_wake} pwr_state_t;

    // PHY controls bundled together
    typedef struct packed {
        logic phy_enable;
        logic refclk_out_en;
        logic suspend;
        logic id_detect_en;
        logic lp_vbus_sense_en;
        logic vbus_comp_en;
        logic sess_end_det_en;
        logic analog_en;
    } phy_ctrl_t;

endpackage

// ### src/pwr_state_ctrl.sv
// Purpose: RESET / IDLE / NORMAL power state sequencing with register access gating
// Assumes: mclk 25 MHz runs while reset is released; gpio pins asynchronous
// Notes: Clock gates are enables for downstream gating cells
`timescale 1ns/100ps

// Function
// - Reset pin low forces RESET state
// - Outputs inactive or tri-stated in RESET
// - Bidirectional pins are inputs in RESET
// - Registers take reset values in RESET
// - PHY and reference clock stay on
// - Enter reset asynchronously, leave synchronously
// - Reset release passes a synchroniser
// - Idle request bit sends device to IDLE
// - Idle outputs low leakage, pulls from registers
// - Idle bidirectional pins at minimum leakage
// - Idle keeps contents, blocks register access
// - Idle switches off internal clocks
// - Idle PHY suspended, ID and LP sense
// - Idle turns off remaining PHY analog
// - Valid wake-up moves IDLE to NORMAL
// - Reset in IDLE goes straight RESET
// - NORMAL allows all register access
// - NORMAL enables all clock sources
// - NORMAL PHY with session-end detect
// - NORMAL keeps ID detection active
// - Per-pin GPIO interrupt or wake source
module pwr_state_ctrl
    import pwr_state_pkg::*;
(
    // Clock and reset
    input wire logic mclk,
    input wire logic rst_n,
    // Avalon-MM slave
    input wire logic [3:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    // General purpose pins
    input wire logic [7:0] gpio_in,
    output logic [7:0] gpio_out,
    output logic [7:0] gpio_oe,
    output logic [7:0] gpio_pull_up,
    output logic [7:0] gpio_pull_down,
    output logic [7:0] gpio_irq,
    // Clock source enables
    output logic core_clk_en,
    output logic osc_en,
    // PHY control
    output phy_ctrl_t phy_ctrl,
    // State view
    output pwr_state_t power_state,
    output logic host_access_en
);

    // ========================================
    // State record
    typedef struct packed {
        logic [1:0] rst_sync;
        logic [7:0] gpio_s1;
        logic [7:0] gpio_s2;
        logic [7:0] gpio_prev;
        pwr_state_t state;
        logic [7:0] settle;
        logic [31:0] gpio_cfg;
        logic [15:0] pull_ctrl;
        logic [7:0] gpio_out_val;
        logic [7:0] gpio_oe_val;
        logic [31:0] rdata;
        logic wait_n;
        logic [7:0] gpio_out;
        logic [7:0] gpio_oe;
        logic [7:0] pull_up;
        logic [7:0] pull_down;
        logic [7:0] irq;
        logic core_clk_en;
        logic osc_en;
        phy_ctrl_t phy;
        logic access_en;
    } regs_t;

    regs_t r_q;
    regs_t r_d;

    // ========================================
    // Byte-lane merge used by the gpio_cfg and pull_ctrl registers
    function automatic logic [31:0] merge_be(input logic [31:0] old_v, input logic [31:0] new_v,
                                             input logic [3:0] be);
        logic [31:0] res;
        res = old_v;
        for (int i = 0; i < 4; i++)
        begin
            if (be[i])
            begin
                res[i*8 +: 8] = new_v[i*8 +: 8];
            end
        end
        return res;
    endfunction

    // PHY settings per state
    function automatic phy_ctrl_t phy_for(input pwr_state_t s);
        phy_ctrl_t p;
        p = '0;
        case (s)
            st_idle:
            begin
                p.suspend = 1'b1;
                p.id_detect_en = 1'b1;
                p.lp_vbus_sense_en = 1'b1;
                // Everything else off, lowest current in suspend
            end
            st_reset:
            begin
                p.phy_enable = 1'b1;
                p.refclk_out_en = 1'b1;
            end
            default:
            begin
                p.phy_enable = 1'b1;
                p.refclk_out_en = 1'b1;
                p.sess_end_det_en = 1'b1;
                p.vbus_comp_en = 1'b1;
                p.id_detect_en = 1'b1;
                p.analog_en = 1'b1;
            end
        endcase
        return p;
    endfunction

    logic [7:0] wake_hits;
    logic [7:0] rise;
    logic sys_rst_n;
    logic bus_req;

    always_comb
    begin
        r_d = r_q;
        // Second stage only is read, release is synchronous
        r_d.rst_sync = {r_q.rst_sync[0], 1'b1};
        sys_rst_n = r_q.rst_sync[1];
        r_d.gpio_s1 = gpio_in;
        r_d.gpio_s2 = r_q.gpio_s1;
        r_d.gpio_prev = r_q.gpio_s2;
        rise = r_q.gpio_s2 & ~r_q.gpio_prev;
        // Level wake so a pin held high during entry is not missed
        wake_hits = r_q.gpio_s2 & r_q.gpio_cfg[wake_en_lsb +: gpio_count];
        r_d.irq = rise & r_q.gpio_cfg[irq_en_lsb +: gpio_count];
        bus_req = avs_read | avs_write;

        r_d.wait_n = 1'b0;
        r_d.rdata = r_q.rdata;

        case (r_q.state)
            st_reset:
            begin
                // Held here until synchronised release
                if (sys_rst_n)
                begin
                    r_d.state = st_normal;
                end
            end
            st_normal:
            begin
                // One-cycle answer per request, second cycle drops wait
                if (bus_req && !r_q.wait_n)
                begin
                    r_d.wait_n = 1'b1;
                    r_d.rdata = unmapped_read;
                    case (avs_address)
                        power_ctrl_addr:
                        begin
                            if (avs_write && avs_byteenable[0]
                                && avs_writedata[idle_request_bit_pos])
                            begin
                                r_d.state = st_idle;
                            end
                        end
                        power_stat_addr:
                        begin
                            // Status fields one by one, unused bits read zero
                            r_d.rdata = unmapped_read;
                            r_d.rdata[1:0] = 2'(r_q.state);
                            r_d.rdata[2] = r_q.access_en;
                            r_d.rdata[15:8] = r_q.gpio_s2;
                        end
                        gpio_cfg_addr:
                        begin
                            r_d.rdata = r_q.gpio_cfg;
                            if (avs_write)
                            begin
                                r_d.gpio_cfg = merge_be(r_q.gpio_cfg, avs_writedata,
                                                        avs_byteenable);
                            end
                        end
                        pull_ctrl_addr:
                        begin
                            r_d.rdata = {16'h0, r_q.pull_ctrl};
                            if (avs_write)
                            begin
                                r_d.pull_ctrl = 16'(merge_be({16'h0, r_q.pull_ctrl},
                                                             avs_writedata, avs_byteenable));
                            end
                        end
                        default:
                        begin
                            r_d.rdata = unmapped_read;
                        end
                    endcase
                end
            end
            st_idle:
            begin
                // Contents kept, requests stall on waitrequest
                if (|wake_hits)
                begin
                    r_d.state = st_wake;
                    r_d.settle = settle_count;
                end
            end
            st_wake:
            begin
                // Clocks run again, access waits for settle count
                if (r_q.settle <= 8'h1)
                begin
                    r_d.state = st_normal;
                end
                else
                begin
                    r_d.settle = r_q.settle - 8'h1;
                end
            end
            default:
            begin
                r_d.state = st_reset;
            end
        endcase

        // Registered outputs follow the next state
        r_d.access_en = (r_d.state == st_normal);
        r_d.core_clk_en = (r_d.state != st_idle);
        r_d.osc_en = (r_d.state != st_idle);
        r_d.phy = phy_for(r_d.state);
        r_d.gpio_out = '0;
        r_d.gpio_oe = '0;
        r_d.pull_up = '0;
        r_d.pull_down = '0;
        if (r_d.state == st_idle)
        begin
            // Pins released, pulls as programmed to avoid floating inputs
            r_d.pull_up = r_q.pull_ctrl[7:0];
            r_d.pull_down = r_q.pull_ctrl[15:8];
        end
        else if (r_d.state != st_reset)
        begin
            r_d.gpio_out = r_q.gpio_cfg[23:16];
            r_d.gpio_oe = r_q.gpio_cfg[31:24];
        end
        // Any idle interrupt is dropped: wake path handles idle pins
        // Entry cycle included, so no pulse shows while already in IDLE
        if (r_q.state == st_idle || r_d.state == st_idle)
        begin
            r_d.irq = '0;
        end
        // Synchronised reset low returns straight to RESET
        if (!sys_rst_n)
        begin
            r_d.state = st_reset;
            r_d.access_en = 1'b0;
            r_d.phy = phy_for(st_reset);
        end
    end

    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            // Asynchronous entry, constants only
            r_q <= '0;
            r_q.state <= st_reset;
            r_q.gpio_cfg <= gpio_cfg_reset;
            r_q.pull_ctrl <= pull_ctrl_reset;
            r_q.phy <= '{phy_enable: 1'b1, refclk_out_en: 1'b1, default: 1'b0};
            r_q.core_clk_en <= 1'b1;
            r_q.osc_en <= 1'b1;
            r_q.gpio_oe <= '0;
        end
        else
        begin
            r_q <= r_d;
        end
    end

    // ========================================
    // Outputs straight from flip-flops
    assign avs_readdata = r_q.rdata;
    assign avs_waitrequest = ~r_q.wait_n;
    assign gpio_out = r_q.gpio_out;
    assign gpio_oe = r_q.gpio_oe;
    assign gpio_pull_up = r_q.pull_up;
    assign gpio_pull_down = r_q.pull_down;
    assign gpio_irq = r_q.irq;
    assign core_clk_en = r_q.core_clk_en;
    assign osc_en = r_q.osc_en;
    assign phy_ctrl = r_q.phy;
    assign power_state = r_q.state;
    assign host_access_en = r_q.access_en;

endmodule

// ### tb/pwr_state_ctrl_asserts.sv
// Purpose: Port checks of power state sequencing
// Assumes: Registered outputs move with power_state
// Notes: Bound to every controller instance
`timescale 1ns/100ps
module pwr_state_asserts
    import pwr_state_pkg::*;
(
    // Clock and reset
    input wire logic mclk,
    input wire logic rst_n,
    // Bus
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic avs_waitrequest,
    // Pins and controls
    input wire logic [7:0] gpio_oe,
    input wire logic [7:0] gpio_irq,
    input wire logic core_clk_en,
    input wire logic osc_en,
    input wire phy_ctrl_t phy_ctrl,
    input wire pwr_state_t power_state,
    input wire logic host_access_en
);
    // ========================================
    // Properties
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);
    a_reset_safe: assert property (
        power_state == st_reset |-> gpio_oe == 8'h00 && phy_ctrl.phy_enable
        && phy_ctrl.refclk_out_en) else $error("reset outputs wrong");
    a_release_sync: assert property (
        $rose(rst_n) |-> (power_state == st_reset) [*3] ##1 power_state == st_normal)
        else $error("reset release not synchronised");
    a_idle_off: assert property (
        power_state == st_idle |-> !core_clk_en && !osc_en && gpio_oe == 8'h00
        && !host_access_en && (avs_waitrequest || $past(power_state) == st_normal))
        else $error("idle not quiet");
    a_idle_phy: assert property (
        power_state == st_idle |-> phy_ctrl.suspend && phy_ctrl.id_detect_en
        && phy_ctrl.lp_vbus_sense_en && !phy_ctrl.vbus_comp_en && !phy_ctrl.analog_en)
        else $error("idle phy wrong");
    a_normal_on: assert property (
        power_state == st_normal |-> core_clk_en && osc_en && phy_ctrl.phy_enable
        && phy_ctrl.sess_end_det_en && phy_ctrl.id_detect_en) else $error("normal off");
    a_access_ans: assert property (
        $rose(avs_read | avs_write) && host_access_en |=> !avs_waitrequest)
        else $error("access not answered");
    a_wait_pulse: assert property (
        !avs_waitrequest |-> $past(avs_read | avs_write) ##1 avs_waitrequest)
        else $error("bad waitrequest pulse");
    a_idle_exit: assert property (
        power_state == st_idle ##1 power_state != st_idle |-> power_state == st_wake)
        else $error("idle left wrongly");
    a_wake_hold: assert property (
        $rose(power_state == st_wake) |-> (!host_access_en && avs_waitrequest) [*8])
        else $error("access during settle");
    a_idle_noirq: assert property (
        power_state == st_idle |-> gpio_irq == 8'h00) else $error("irq in idle");
    cover property (power_state == st_idle);
    cover property (power_state == st_wake);
    cover property (!avs_waitrequest && avs_write);
endmodule
bind pwr_state_ctrl pwr_state_asserts chk (.mclk(mclk), .rst_n(rst_n),
    .avs_read(avs_read), .avs_write(avs_write), .avs_waitrequest(avs_waitrequest),
    .gpio_oe(gpio_oe), .gpio_irq(gpio_irq), .core_clk_en(core_clk_en),
    .osc_en(osc_en), .phy_ctrl(phy_ctrl), .power_state(power_state),
    .host_access_en(host_access_en));

// ### tb/host_model.sv
// Purpose: Host processor model on the register bus
// Assumes: Slave answers with one low waitrequest cycle
// Notes: Reports cycles waited so the caller can time out
`timescale 1ns/100ps
module host_model
    import pwr_state_pkg::*;
(
    // Clock
    input wire logic mclk,
    // Avalon-MM master
    output logic [3:0] avs_address,
    output logic avs_read,
    output logic avs_write,
    output logic [31:0] avs_writedata,
    output logic [3:0] avs_byteenable,
    input wire logic [31:0] avs_readdata,
    input wire logic avs_waitrequest
);
    logic wait_s = 1'b1;
    logic [31:0] data_s;
    initial {avs_address, avs_read, avs_write, avs_writedata, avs_byteenable} = '0;
    // Captured half a cycle early so the edge decision never races the design
    always @(negedge mclk)
    begin
        wait_s <= avs_waitrequest;
        data_s <= avs_readdata;
    end
    task automatic xfer(input logic wr, input logic [3:0] a, input logic [31:0] d,
        input logic [3:0] be, output logic [31:0] q, output int n);
        @(posedge mclk);
        avs_address <= a;
        avs_read <= !wr;
        avs_write <= wr;
        avs_writedata <= d;
        avs_byteenable <= be;
        n = 0;
        do
        begin
            @(posedge mclk);
            n++;
        end
        while (wait_s !== 1'b0 && n < 200);
        q = data_s;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
    endtask
endmodule

// ### tb/tb.sv
// Purpose: Self-checking bench of the power state controller
// Assumes: Reference model tracks the writable registers
// Notes: Random data from a fixed seed
`timescale 1ns/100ps
`define CHK(nm, e, g) begin tests_run++; if ((g) !== (e)) begin mismatches++; \
    $display("FAIL %s expected %h seen %h", nm, e, g); end end
module tb
    import pwr_state_pkg::*;
;
    logic mclk, rst_n;
    logic [7:0] gpio_in, gpio_out, gpio_oe, gpio_pull_up, gpio_pull_down, gpio_irq;
    logic [3:0] avs_address, avs_byteenable;
    logic avs_read, avs_write, avs_waitrequest, core_clk_en, osc_en, host_access_en;
    logic [31:0] avs_writedata, avs_readdata;
    phy_ctrl_t phy_ctrl;
    pwr_state_t power_state;
    logic [31:0] mreg [4];
    int mismatches = 0;
    int tests_run = 0;
    pwr_state_ctrl dut (.mclk(mclk), .rst_n(rst_n), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .gpio_in(gpio_in), .gpio_out(gpio_out),
        .gpio_oe(gpio_oe), .gpio_pull_up(gpio_pull_up), .gpio_pull_down(gpio_pull_down),
        .gpio_irq(gpio_irq), .core_clk_en(core_clk_en), .osc_en(osc_en),
        .phy_ctrl(phy_ctrl), .power_state(power_state), .host_access_en(host_access_en));
    host_model host (.mclk(mclk), .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest));
    // ========================================
    // Tasks
    task automatic finish_test();
        $display("Checks %0d mismatches %0d", tests_run, mismatches);
        if (mismatches == 0 && tests_run > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d,
        input logic [3:0] be, output logic [31:0] q, output int n);
        host.xfer(wr, a, d, be, q, n);
        if (n >= 200)
        begin
            mismatches++;
            finish_test();
        end
        if (wr && a[3])
            for (int i = 0; i < 4; i++)
                if (be[i])
                    mreg[a[3:2]][8*i+:8] = d[8*i+:8];
        // Pull register holds only 16 bits, upper half reads zero
        mreg[3] = mreg[3] & 32'h0000_ffff;
    endtask
    task automatic idle_up();
        logic [31:0] q;
        int n;
        bus(1'b1, power_ctrl_addr, 32'h1 << idle_request_bit_pos, 4'hf, q, n);
        n = 0;
        while (power_state !== st_idle && n < 20)
        begin
            @(negedge mclk);
            n++;
        end
        `CHK("idle entry", st_idle, power_state)
    endtask
    // ========================================
    // Sequence
    initial
    begin
        mclk = 1'b0;
        forever #20 mclk = ~mclk;
    end
    initial
    begin
        logic [31:0] q, v;
        int n;
        rst_n = 1'b0;
        gpio_in = 8'h00;
        mreg = '{32'h0, 32'h0, gpio_cfg_reset, 32'(pull_ctrl_reset)};
        void'($urandom(32'hd8cb));
        repeat (12) @(posedge mclk);
        `CHK("reset oe", 8'h00, gpio_oe)
        `CHK("reset phy", 2'b11, {phy_ctrl.phy_enable, phy_ctrl.refclk_out_en})
        rst_n <= 1'b1;
        repeat (3) @(posedge mclk);
        for (int k = 0; k < 6; k++)
        begin
            if (k > 1)
                bus(1'b1, 4'h8 + 4'(k % 2) * 4'h4, $urandom & 32'h00ff_ffff, 4'($urandom), q, n);
            bus(1'b0, 4'h8 + 4'(k % 2) * 4'h4, 32'h0, 4'hf, q, n);
            `CHK("reg read", mreg[2 + k % 2], q)
        end
        bus(1'b0, power_stat_addr, 32'h0, 4'hf, q, n);
        `CHK("status", {1'b1, st_normal}, q[2:0])
        v = $urandom & 32'hffff;
        bus(1'b1, pull_ctrl_addr, v, 4'hf, q, n);
        bus(1'b1, gpio_cfg_addr, 32'hff00_0800, 4'hf, q, n);
        idle_up();
        `CHK("idle pulls", mreg[3][15:0], {gpio_pull_down, gpio_pull_up})
        `CHK("idle clocks", 2'b00, {core_clk_en, osc_en})
        `CHK("idle oe", 8'h00, gpio_oe)
        fork
            bus(1'b0, gpio_cfg_addr, 32'h0, 4'hf, q, n);
            begin
                repeat (10) @(posedge mclk);
                gpio_in <= 8'h08;
            end
        join
        `CHK("kept cfg", mreg[2], q)
        `CHK("blocked wait", 1'b1, n >= 10 + 2 + 25)
        `CHK("woken", st_normal, power_state)
        `CHK("normal oe", mreg[2][31:24], gpio_oe)
        `CHK("normal out", mreg[2][23:16], gpio_out)
        `CHK("normal pulls", 16'h0000, {gpio_pull_down, gpio_pull_up})
        `CHK("normal access", 1'b1, host_access_en)
        gpio_in <= 8'h00;
        bus(1'b1, gpio_cfg_addr, 32'h0000_00ff, 4'hf, q, n);
        v = $urandom | 32'h1;
        gpio_in <= v[7:0];
        q = '0;
        repeat (6)
        begin
            @(negedge mclk);
            q[7:0] = q[7:0] | gpio_irq;
        end
        `CHK("irq", v[7:0], q[7:0])
        gpio_in <= 8'h00;
        bus(1'b1, gpio_cfg_addr, $urandom, 4'hf, q, n);
        idle_up();
        @(posedge mclk);
        rst_n <= 1'b0;
        @(negedge mclk);
        `CHK("reset from idle", st_reset, power_state)
        mreg[2] = gpio_cfg_reset;
        mreg[3] = 32'(pull_ctrl_reset);
        repeat (12) @(posedge mclk);
        rst_n <= 1'b1;
        repeat (3) @(posedge mclk);
        bus(1'b0, gpio_cfg_addr, 32'h0, 4'hf, q, n);
        `CHK("cfg after reset", mreg[2], q)
        finish_test();
    end
endmodule
